// File: hw/mafe_pkg.sv
// Package of constants and carrier types for the modem front-end line control core
package mafe_pkg;
    // Transmit output setting codes
    localparam logic [1:0] TX_MUTE = 2'h0;
    localparam logic [1:0] TX_P2DB = 2'h1;
    localparam logic [1:0] TX_M6DB = 2'h2;
    localparam logic [1:0] TX_0DB = 2'h3;
    // Line state codes {caller_id_bit, offhook_bit}
    localparam logic [1:0] LS_ONHOOK = 2'h0;
    localparam logic [1:0] LS_OFFHOOK = 2'h1;
    localparam logic [1:0] LS_CLID = 2'h2;
    // Full-scale sample codes
    localparam logic [15:0] FS_POS = 16'h7FFF;
    localparam logic [15:0] FS_NEG = 16'h8000;
    // Slot boundaries, bit counts after frame-sync fall
    localparam logic [5:0] SLOT_BITS = 6'h10;
    localparam logic [5:0] FRAME_BITS = 6'h20;
    // Wake delay after power-down release
    localparam int WAKE_TIME_US = 1000;
    localparam int CLK_MHZ = 40;
    localparam int WAKE_CYCLES = WAKE_TIME_US * CLK_MHZ;
    localparam logic [3:0] GPIO_RESET_DIR = 4'h0;
    localparam logic [15:0] DIV_DEFAULT = 16'h0004;

    typedef struct packed {
        logic [1:0] tx_setting;
        logic rx_gain_6db;
        logic rx_aux_select;
        logic pd_mode_wake;
        logic caller_id_bit;
        logic offhook_bit;
    } mafe_cfg_s;

    typedef struct packed {
        logic [3:0] dir_out;
        logic [3:0] out_val;
        logic [3:0] mask;
        logic ring_mask;
        logic clk_div_en;
        logic clk_raw_en;
    } mafe_gpio_cfg_s;

    typedef enum logic [1:0] {
        PD_RUN,
        PD_OFF,
        PD_WAKE_IRQ,
        PD_RESUME
    } mafe_pd_e;
endpackage

// File: hw/mafe_line_ctrl.sv
// Line, clock, power-down and general-purpose pin control core
//
// Summary of operation
// - Four transmit settings: +2, 0, -6 dB, mute
// - Main receive gain 0 or 6 dB
// - Mux selects main or auxiliary receive input
// - Select low bypasses M and Q dividers
// - Both high: master, frame = xtal/(M*Q*OVER)
// - Select low, master: frame = xtal/OVER
// - Timeslot select, not master mode, picks slots 0-15 or 16-31
// - Mode bit clear, pin low: full power-down
// - Mode bit set: keep ring and interrupt alive
// - All masked: port off until pin high
// - Unmasked event: interrupt and wake serial port
// - After status read, port off again
// - Pin zero divided clock, pin three carrier
// - Line state from pins or register bits
// - Unmasked input change toggles interrupt output
// - On-hook: both barrier outputs held high
// - On-hook: ring output and status mirror ring
// - Off-hook: carrier on both, opposite phase
// - Caller ID: carrier on A, B high, half demod
// - Saturated converter gives full-scale sample codes
// - Resume after one millisecond, config kept
// - Timeslot low: first sixteen bits, else next
// - General-purpose pins reset to inputs
`timescale 1ns/1ps
module mafe_line_ctrl #(
    parameter int WAKE_COUNT = mafe_pkg::WAKE_CYCLES
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire mafe_pkg::mafe_cfg_s cfg,
    input wire mafe_pkg::mafe_gpio_cfg_s gpio_cfg,
    input wire logic [15:0] div_n,
    input wire logic [15:0] div_mq,
    input wire logic [15:0] over_ratio,
    input wire logic divider_path_select,
    input wire logic master_mode,
    input wire logic timeslot_select,
    input wire logic hook_control_source,
    input wire logic power_down_n,
    input wire logic frame_sync_in,
    input wire logic ring_detect_in,
    input wire logic rx_saturated,
    input wire logic rx_sat_polarity,
    input wire logic [15:0] rx_sample_in,
    input wire logic status_read,
    input wire logic [3:0] gp_pin_in,
    output logic [3:0] gp_pin_out,
    output logic [3:0] gp_pin_oe,
    output logic general_interrupt_out,
    output logic barrier_ctrl_a,
    output logic barrier_ctrl_b,
    output logic ring_out,
    output logic [5:0] status_bits,
    output logic [1:0] tx_gain_sel,
    output logic rx_gain_sel,
    output logic rx_aux_sel,
    output logic demod_half_rate,
    output logic frame_sync_out,
    output logic frame_sync_oe,
    output logic slot_active,
    output logic [15:0] rx_sample_out,
    output logic analog_power_en,
    output logic serial_port_en,
    output logic ring_path_en
);
    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [5:0] sync1_reg;
    logic [5:0] sync2_reg;
    logic [5:0] prev_reg;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sync1_reg <= 6'h3F;
            sync2_reg <= 6'h3F;
            prev_reg <= 6'h3F;
        end else if (clk_en) begin
            sync1_reg <= {frame_sync_in, ring_detect_in, gp_pin_in};
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end
    logic [3:0] gp_in_s;
    logic ring_s;
    logic fs_in_s;
    assign gp_in_s = sync2_reg[3:0];
    assign ring_s = sync2_reg[4];
    assign fs_in_s = sync2_reg[5];

    // ****************************************
    // Line state and carrier
    // ****************************************
    logic [1:0] line_state;
    assign line_state = hook_control_source ? {gp_in_s[1], gp_in_s[2]}
                                            : {cfg.caller_id_bit, cfg.offhook_bit};
    logic carrier_reg;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            carrier_reg <= 1'b0;
        end else if (clk_en) begin
            carrier_reg <= ~carrier_reg;
        end
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            barrier_ctrl_a <= 1'b1;
            barrier_ctrl_b <= 1'b1;
            demod_half_rate <= 1'b0;
        end else if (clk_en) begin
            unique case (line_state)
                mafe_pkg::LS_ONHOOK: begin
                    barrier_ctrl_a <= 1'b1;
                    barrier_ctrl_b <= 1'b1;
                    demod_half_rate <= 1'b0;
                end
                mafe_pkg::LS_OFFHOOK: begin
                    barrier_ctrl_a <= ~carrier_reg;
                    barrier_ctrl_b <= carrier_reg;
                    demod_half_rate <= 1'b0;
                end
                mafe_pkg::LS_CLID: begin
                    barrier_ctrl_a <= ~carrier_reg;
                    barrier_ctrl_b <= 1'b1;
                    demod_half_rate <= 1'b1;
                end
                default: begin
                    // Special state: barrier left quiet
                    barrier_ctrl_a <= 1'b1;
                    barrier_ctrl_b <= 1'b1;
                    demod_half_rate <= 1'b0;
                end
            endcase
        end
    end
    // Ring image only meaningful while on-hook
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ring_out <= 1'b0;
            status_bits <= 6'h00;
        end else if (clk_en) begin
            ring_out <= (line_state == mafe_pkg::LS_ONHOOK) & ring_s;
            status_bits <= {(line_state == mafe_pkg::LS_ONHOOK) & ring_s, 1'b0, gp_in_s};
        end
    end

    // ****************************************
    // Analog path settings
    // ****************************************
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            tx_gain_sel <= mafe_pkg::TX_MUTE;
            rx_gain_sel <= 1'b0;
            rx_aux_sel <= 1'b0;
        end else if (clk_en) begin
            tx_gain_sel <= cfg.tx_setting;
            rx_gain_sel <= cfg.rx_gain_6db;
            rx_aux_sel <= cfg.rx_aux_select;
        end
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rx_sample_out <= 16'h0000;
        end else if (clk_en) begin
            if (rx_saturated) begin
                rx_sample_out <= rx_sat_polarity ? mafe_pkg::FS_NEG : mafe_pkg::FS_POS;
            end else begin
                rx_sample_out <= rx_sample_in;
            end
        end
    end

    // ****************************************
    // Frame sync generation and slot
    // ****************************************
    logic [31:0] fs_div;
    logic [31:0] fs_cnt_reg;
    // Bypass drops M and Q from the divide chain
    assign fs_div = divider_path_select ? (32'(div_mq) * 32'(over_ratio))
                                        : 32'(over_ratio);
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            fs_cnt_reg <= 32'h0000_0000;
            frame_sync_out <= 1'b1;
            frame_sync_oe <= 1'b0;
        end else if (clk_en) begin
            frame_sync_oe <= master_mode;
            if (fs_cnt_reg + 32'h0000_0001 >= fs_div) begin
                fs_cnt_reg <= 32'h0000_0000;
            end else begin
                fs_cnt_reg <= fs_cnt_reg + 32'h0000_0001;
            end
            frame_sync_out <= (fs_cnt_reg != 32'h0000_0000);
        end
    end
    logic fs_act;
    logic fs_prev_reg;
    logic [5:0] bit_cnt_reg;
    assign fs_act = master_mode ? frame_sync_out : fs_in_s;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            fs_prev_reg <= 1'b1;
            bit_cnt_reg <= mafe_pkg::FRAME_BITS;
            slot_active <= 1'b0;
        end else if (clk_en) begin
            fs_prev_reg <= fs_act;
            if (fs_prev_reg && !fs_act) begin
                bit_cnt_reg <= 6'h00;
            end else if (bit_cnt_reg < mafe_pkg::FRAME_BITS) begin
                bit_cnt_reg <= bit_cnt_reg + 6'h01;
            end
            slot_active <= (bit_cnt_reg < mafe_pkg::FRAME_BITS) &&
                (timeslot_select ? (bit_cnt_reg >= mafe_pkg::SLOT_BITS)
                                 : (bit_cnt_reg < mafe_pkg::SLOT_BITS));
        end
    end

    // ****************************************
    // General-purpose pins and interrupt
    // ****************************************
    logic [15:0] div_cnt_reg;
    logic div_clk_reg;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            div_cnt_reg <= 16'h0000;
            div_clk_reg <= 1'b0;
        end else if (clk_en) begin
            if (div_cnt_reg + 16'h0001 >= div_n) begin
                div_cnt_reg <= 16'h0000;
                div_clk_reg <= ~div_clk_reg;
            end else begin
                div_cnt_reg <= div_cnt_reg + 16'h0001;
            end
        end
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            gp_pin_oe <= mafe_pkg::GPIO_RESET_DIR;
            gp_pin_out <= 4'h0;
        end else if (clk_en) begin
            gp_pin_oe <= gpio_cfg.dir_out;
            gp_pin_out[0] <= gpio_cfg.out_val[0] &
                (gpio_cfg.clk_div_en ? div_clk_reg : 1'b1);
            gp_pin_out[2:1] <= gpio_cfg.out_val[2:1];
            gp_pin_out[3] <= gpio_cfg.out_val[3] &
                (gpio_cfg.clk_raw_en ? carrier_reg : 1'b1);
        end
    end
    logic [3:0] gp_change;
    logic irq_event;
    logic any_unmasked;
    assign gp_change = (gp_in_s ^ prev_reg[3:0]) & gpio_cfg.mask & ~gpio_cfg.dir_out;
    assign irq_event = (|gp_change) | ((ring_s ^ prev_reg[4]) & gpio_cfg.ring_mask);
    assign any_unmasked = (|(gpio_cfg.mask & ~gpio_cfg.dir_out)) | gpio_cfg.ring_mask;
    // Level change, not a pulse: host reacts to either edge
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            general_interrupt_out <= 1'b0;
        end else if (clk_en && irq_event) begin
            general_interrupt_out <= ~general_interrupt_out;
        end
    end

    // ****************************************
    // Power-down sequencing
    // ****************************************
    logic pd_pin_s1_reg;
    logic pd_pin_s2_reg;
    mafe_pkg::mafe_pd_e pd_reg;
    logic [31:0] wake_cnt_reg;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pd_pin_s1_reg <= 1'b1;
            pd_pin_s2_reg <= 1'b1;
        end else if (clk_en) begin
            pd_pin_s1_reg <= power_down_n;
            pd_pin_s2_reg <= pd_pin_s1_reg;
        end
    end
    // Configuration inputs are untouched here, so settings survive power-down
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pd_reg <= mafe_pkg::PD_RUN;
            wake_cnt_reg <= 32'h0000_0000;
        end else if (clk_en) begin
            unique case (pd_reg)
                mafe_pkg::PD_RUN: begin
                    if (!pd_pin_s2_reg) begin
                        pd_reg <= mafe_pkg::PD_OFF;
                    end
                end
                mafe_pkg::PD_OFF: begin
                    if (pd_pin_s2_reg) begin
                        pd_reg <= mafe_pkg::PD_RESUME;
                        wake_cnt_reg <= 32'h0000_0000;
                    end else if (cfg.pd_mode_wake && any_unmasked && irq_event) begin
                        pd_reg <= mafe_pkg::PD_WAKE_IRQ;
                    end
                end
                mafe_pkg::PD_WAKE_IRQ: begin
                    if (pd_pin_s2_reg) begin
                        pd_reg <= mafe_pkg::PD_RESUME;
                        wake_cnt_reg <= 32'h0000_0000;
                    end else if (status_read) begin
                        pd_reg <= mafe_pkg::PD_OFF;
                    end
                end
                mafe_pkg::PD_RESUME: begin
                    if (!pd_pin_s2_reg) begin
                        pd_reg <= mafe_pkg::PD_OFF;
                    end else if (wake_cnt_reg >= 32'(WAKE_COUNT - 1)) begin
                        pd_reg <= mafe_pkg::PD_RUN;
                    end else begin
                        wake_cnt_reg <= wake_cnt_reg + 32'h0000_0001;
                    end
                end
            endcase
        end
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            analog_power_en <= 1'b1;
            serial_port_en <= 1'b1;
            ring_path_en <= 1'b1;
        end else if (clk_en) begin
            analog_power_en <= (pd_reg == mafe_pkg::PD_RUN);
            serial_port_en <= (pd_reg == mafe_pkg::PD_RUN) ||
                (pd_reg == mafe_pkg::PD_WAKE_IRQ);
            ring_path_en <= (pd_reg == mafe_pkg::PD_RUN) || cfg.pd_mode_wake;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    a_onhook_quiet: assert property (@(posedge clk_sys) disable iff (!arst_n)
        clk_en && line_state == mafe_pkg::LS_ONHOOK |=> barrier_ctrl_a && barrier_ctrl_b)
        else $error("barrier outputs not high on-hook");
    a_offhook_opposite: assert property (@(posedge clk_sys) disable iff (!arst_n)
        clk_en && line_state == mafe_pkg::LS_OFFHOOK |=> barrier_ctrl_a != barrier_ctrl_b)
        else $error("barrier outputs not opposite off-hook");
    a_clid_b_high: assert property (@(posedge clk_sys) disable iff (!arst_n)
        clk_en && line_state == mafe_pkg::LS_CLID |=> barrier_ctrl_b && demod_half_rate)
        else $error("caller id barrier state wrong");
    a_sat_code: assert property (@(posedge clk_sys) disable iff (!arst_n)
        clk_en && rx_saturated |=> rx_sample_out == mafe_pkg::FS_POS ||
            rx_sample_out == mafe_pkg::FS_NEG)
        else $error("saturated sample not full scale");
    a_irq_toggle: assert property (@(posedge clk_sys) disable iff (!arst_n)
        clk_en && irq_event |=> general_interrupt_out != $past(general_interrupt_out))
        else $error("interrupt output missed a change");
    a_ring_mirror: assert property (@(posedge clk_sys) disable iff (!arst_n)
        clk_en |=> ring_out == status_bits[5])
        else $error("ring status bit differs from pin");
    a_wake_port: assert property (@(posedge clk_sys) disable iff (!arst_n)
        clk_en && pd_reg == mafe_pkg::PD_WAKE_IRQ && status_read && !pd_pin_s2_reg
        |=> pd_reg == mafe_pkg::PD_OFF)
        else $error("serial port not shut after status read");
    a_pd_off: assert property (@(posedge clk_sys) disable iff (!arst_n)
        clk_en && pd_reg == mafe_pkg::PD_OFF |=> !analog_power_en)
        else $error("analog powered while down");
    c_offhook: cover property (@(posedge clk_sys) disable iff (!arst_n)
        line_state == mafe_pkg::LS_OFFHOOK);
    c_wake_irq: cover property (@(posedge clk_sys) disable iff (!arst_n)
        pd_reg == mafe_pkg::PD_WAKE_IRQ);
    c_resume: cover property (@(posedge clk_sys) disable iff (!arst_n)
        pd_reg == mafe_pkg::PD_RESUME ##1 pd_reg == mafe_pkg::PD_RUN);
endmodule // mafe_line_ctrl

// File: sim/mafe_host_model.sv
// Host-side frame sync source for slave-mode runs
`timescale 1ns/1ps
module mafe_host_model (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic fs_enable,
    input wire logic [15:0] fs_period,
    output logic frame_sync_in
);
    logic [15:0] cnt_reg;

    // ****************
    // Frame generator
    // ****************
    // Host owns frame rate and phase in slave modes
    always_ff @(negedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg <= 16'h0000;
            frame_sync_in <= 1'b1;
        end else if (!fs_enable) begin
            cnt_reg <= 16'h0000;
            frame_sync_in <= 1'b1;
        end else begin
            cnt_reg <= (cnt_reg == fs_period - 16'h0001) ? 16'h0000 : cnt_reg + 16'h0001;
            // One-cycle high; its fall opens the frame
            frame_sync_in <= (cnt_reg == 16'h0000);
        end
    end
endmodule // mafe_host_model

// File: sim/mafe_line_ctrl_tb.sv
// Self-checking bench for the line control core
`timescale 1ns/1ps
module mafe_line_ctrl_tb;
    // ****************
    // Signals
    // ****************
    logic clk_sys, arst_n, clk_en, host_en;
    mafe_pkg::mafe_cfg_s cfg;
    mafe_pkg::mafe_gpio_cfg_s gpio_cfg;
    logic [15:0] div_n, div_mq, over_ratio, rx_sample_in, rx_sample_out;
    logic divider_path_select, master_mode, timeslot_select, hook_control_source;
    logic power_down_n, frame_sync_in, ring_detect_in, rx_saturated, rx_sat_polarity;
    logic status_read, general_interrupt_out, barrier_ctrl_a, barrier_ctrl_b, ring_out;
    logic [3:0] gp_pin_in, gp_pin_out, gp_pin_oe;
    logic [5:0] status_bits;
    logic [1:0] tx_gain_sel;
    logic rx_gain_sel, rx_aux_sel, demod_half_rate, frame_sync_out, frame_sync_oe;
    logic slot_active, analog_power_en, serial_port_en, ring_path_en, irq0;
    int fail_count, n_tests, ta, na1, nb1, ndiff, tg0, tg3, tfs, ts;

    // Short wake count keeps the power tests brief
    mafe_line_ctrl #(.WAKE_COUNT(20)) i_mafe_line_ctrl (.clk_sys(clk_sys), .arst_n(arst_n),
        .clk_en(clk_en), .cfg(cfg), .gpio_cfg(gpio_cfg), .div_n(div_n), .div_mq(div_mq),
        .over_ratio(over_ratio), .divider_path_select(divider_path_select),
        .master_mode(master_mode), .timeslot_select(timeslot_select),
        .hook_control_source(hook_control_source), .power_down_n(power_down_n),
        .frame_sync_in(frame_sync_in), .ring_detect_in(ring_detect_in),
        .rx_saturated(rx_saturated), .rx_sat_polarity(rx_sat_polarity),
        .rx_sample_in(rx_sample_in), .status_read(status_read), .gp_pin_in(gp_pin_in),
        .gp_pin_out(gp_pin_out), .gp_pin_oe(gp_pin_oe),
        .general_interrupt_out(general_interrupt_out), .barrier_ctrl_a(barrier_ctrl_a),
        .barrier_ctrl_b(barrier_ctrl_b), .ring_out(ring_out), .status_bits(status_bits),
        .tx_gain_sel(tx_gain_sel), .rx_gain_sel(rx_gain_sel), .rx_aux_sel(rx_aux_sel),
        .demod_half_rate(demod_half_rate), .frame_sync_out(frame_sync_out),
        .frame_sync_oe(frame_sync_oe), .slot_active(slot_active),
        .rx_sample_out(rx_sample_out), .analog_power_en(analog_power_en),
        .serial_port_en(serial_port_en), .ring_path_en(ring_path_en));

    mafe_host_model i_mafe_host_model (.clk_sys(clk_sys), .arst_n(arst_n),
        .fs_enable(host_en), .fs_period(16'h0028), .frame_sync_in(frame_sync_in));

    // ****************
    // Tasks
    // ****************
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask

    // Counts may slip by one at window edges
    task automatic near(input string nm, input int e, input int g);
        chk(nm, 16'h0001, {15'h0000, (g >= e - 1 && g <= e + 1)});
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // Watches wire activity over a window of n cycles
    task automatic run(input int n);
        logic pa, p0, p3, pf, ps;
        {ta, na1, nb1, ndiff, tg0, tg3, tfs, ts} = '0;
        {pa, p0, p3, pf, ps} = {barrier_ctrl_a, gp_pin_out[0], gp_pin_out[3], frame_sync_out,
            slot_active};
        repeat (n) begin
            @(negedge clk_sys);
            ta += int'(barrier_ctrl_a !== pa);
            na1 += int'(barrier_ctrl_a === 1'b1);
            nb1 += int'(barrier_ctrl_b === 1'b1);
            ndiff += int'(barrier_ctrl_a !== barrier_ctrl_b);
            tg0 += int'(gp_pin_out[0] !== p0);
            tg3 += int'(gp_pin_out[3] !== p3);
            tfs += int'(frame_sync_out !== pf);
            ts += int'(slot_active !== ps);
            {pa, p0, p3, pf, ps} = {barrier_ctrl_a, gp_pin_out[0], gp_pin_out[3],
                frame_sync_out, slot_active};
        end
    endtask

    task automatic stop_test();
        if (fail_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ****************
    // Clock, watchdog
    // ****************
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    initial begin
        #500000;
        fail_count++;
        stop_test();
    end

    // ****************
    // Tests
    // ****************
    initial begin
        {fail_count, n_tests} = '0;
        {arst_n, clk_en, host_en, cfg, gpio_cfg} = '0;
        clk_en = 1'b1;
        {div_n, div_mq, over_ratio} = {16'h0003, 16'h0003, 16'h0008};
        {divider_path_select, master_mode, timeslot_select, hook_control_source} = 4'h4;
        {power_down_n, ring_detect_in, rx_saturated, rx_sat_polarity, status_read} = 5'h18;
        rx_sample_in = 16'h1234;
        gp_pin_in = 4'hF;
        cyc(2);
        chk("barrier_a_rst", 1, barrier_ctrl_a);
        cyc(1);
        arst_n = 1'b1;
        cyc(4);
        chk("oe_rst", 0, gp_pin_oe);
        chk("sample", 16'h1234, rx_sample_out);
        for (int i = 0; i < 4; i++) begin
            cfg.tx_setting = 2'(i);
            cyc(2);
            chk("tx_gain", 16'(i), tx_gain_sel);
        end
        // Enable low must hold every register
        clk_en = 1'b0;
        cfg.tx_setting = 2'h1;
        cyc(3);
        chk("frozen", 3, tx_gain_sel);
        clk_en = 1'b1;
        cfg.tx_setting = 2'h3;
        {cfg.rx_gain_6db, cfg.rx_aux_select} = 2'h3;
        cyc(2);
        chk("rx_gain", 1, rx_gain_sel);
        chk("rx_aux", 1, rx_aux_sel);
        {cfg.rx_gain_6db, cfg.rx_aux_select} = 2'h0;
        cyc(2);
        chk("rx_aux0", 0, rx_aux_sel);
        for (int h = 0; h < 2; h++) begin
            for (int s = 0; s < 3; s++) begin
                if (h == 1) begin
                    {gp_pin_in[1], gp_pin_in[2]} = 2'(s);
                end else begin
                    {cfg.caller_id_bit, cfg.offhook_bit} = 2'(s);
                end
                hook_control_source = h[0];
                cyc(6);
                run(100);
                chk("demod_half", 16'(s == 2), demod_half_rate);
                if (s == 0) begin
                    chk("onhook_a", 100, 16'(na1));
                    chk("onhook_b", 100, 16'(nb1));
                end else begin
                    chk("carrier_a", 1, 16'(ta > 0));
                    chk(s == 1 ? "offhook_inv" : "clid_b", 100, 16'(s == 1 ? ndiff : nb1));
                end
            end
        end
        {cfg.caller_id_bit, cfg.offhook_bit, hook_control_source} = 3'h0;
        gp_pin_in = 4'hF;
        cyc(6);
        ring_detect_in = 1'b0;
        cyc(5);
        chk("ring_out", 0, ring_out);
        chk("status", 6'h0F, status_bits);
        ring_detect_in = 1'b1;
        cyc(5);
        chk("status1", 6'h2F, status_bits);
        chk("ring_out1", 1, ring_out);
        gpio_cfg.mask = 4'h1;
        irq0 = general_interrupt_out;
        gp_pin_in[0] = 1'b0;
        cyc(8);
        chk("irq_pin0", {15'h0000, ~irq0}, general_interrupt_out);
        gp_pin_in[1] = 1'b0;
        cyc(5);
        chk("irq_masked", {15'h0000, ~irq0}, general_interrupt_out);
        gp_pin_in = 4'hF;
        cyc(5);
        chk("irq_back", 16'(irq0), general_interrupt_out);
        gpio_cfg.mask = 4'h0;
        rx_saturated = 1'b1;
        for (int p = 0; p < 2; p++) begin
            rx_sat_polarity = p[0];
            cyc(2);
            chk("sat", p ? mafe_pkg::FS_NEG : mafe_pkg::FS_POS, rx_sample_out);
        end
        rx_saturated = 1'b0;
        {gpio_cfg.dir_out, gpio_cfg.out_val, gpio_cfg.clk_div_en, gpio_cfg.clk_raw_en} = 10'h267;
        cyc(4);
        run(60);
        chk("gp_oe", 4'h9, gp_pin_oe);
        near("gp0_div", 20, tg0);
        chk("gp3_clk", 1, 16'(tg3 > 0));
        {gpio_cfg.clk_div_en, gpio_cfg.clk_raw_en} = 2'h0;
        cyc(4);
        chk("gp_static", 4'h9, gp_pin_out & 4'h9);
        gpio_cfg.dir_out = 4'h0;
        // Frame must outlast the first slot or the slot never closes
        over_ratio = 16'h0030;
        cyc(50);
        run(96);
        chk("fs_oe", 1, frame_sync_oe);
        near("fs_bypass", 4, tfs);
        chk("slot0", 1, 16'(ts > 0));
        divider_path_select = 1'b1;
        cyc(150);
        run(288);
        near("fs_div", 4, tfs);
        {master_mode, timeslot_select, host_en} = 3'h3;
        cyc(4);
        run(120);
        chk("fs_slave", 0, frame_sync_oe);
        chk("slot1", 1, 16'(ts > 0));
        divider_path_select = 1'b0;
        cyc(4);
        chk("fs_slave2", 0, frame_sync_oe);
        {master_mode, timeslot_select, host_en} = 3'h4;
        power_down_n = 1'b0;
        cyc(6);
        chk("pd0", 0, {analog_power_en, serial_port_en, ring_path_en});
        power_down_n = 1'b1;
        cyc(10);
        chk("wake_early", 0, analog_power_en);
        cyc(20);
        chk("wake", 1, analog_power_en);
        chk("cfg_kept", 3, tx_gain_sel);
        cfg.pd_mode_wake = 1'b1;
        power_down_n = 1'b0;
        ring_detect_in = 1'b0;
        cyc(6);
        chk("pd1", 2'h1, {analog_power_en, ring_path_en});
        chk("ring_pd", 0, ring_out);
        // Masked ring change while down must leave the port off
        ring_detect_in = 1'b1;
        cyc(5);
        chk("port_off", 0, serial_port_en);
        gpio_cfg.ring_mask = 1'b1;
        cyc(2);
        irq0 = general_interrupt_out;
        ring_detect_in = 1'b0;
        cyc(6);
        chk("wake_port", 1, serial_port_en);
        chk("wake_irq", {15'h0000, ~irq0}, general_interrupt_out);
        status_read = 1'b1;
        cyc(1);
        status_read = 1'b0;
        cyc(3);
        chk("port_reoff", 0, serial_port_en);
        power_down_n = 1'b1;
        cyc(30);
        chk("port_up", 1, serial_port_en);
        stop_test();
    end
endmodule // mafe_line_ctrl_tb
